// file: ftcf_consts.svh
`ifndef FTCF_CONSTS_SVH
`define FTCF_CONSTS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define FTCF_CLK_NS 4
// Nominal bit time at 125 kbaud
`define FTCF_BIT_NS 8000
`define FTCF_BIT_CYC ((`FTCF_BIT_NS + `FTCF_CLK_NS - 1) / `FTCF_CLK_NS)
`define FTCF_REMOTE_BITS 5
`define FTCF_REMOTE_CYC (`FTCF_REMOTE_BITS * `FTCF_BIT_CYC)
// Single-wire entry and exit filters
`define FTCF_ENTRY_NS 20000
`define FTCF_ENTRY_CYC ((`FTCF_ENTRY_NS + `FTCF_CLK_NS - 1) / `FTCF_CLK_NS)
`define FTCF_EXIT_NS 40000
`define FTCF_EXIT_CYC ((`FTCF_EXIT_NS + `FTCF_CLK_NS - 1) / `FTCF_CLK_NS)
// Permanent dominant limit on transmit data
`define FTCF_DOM_NS 2000000
`define FTCF_DOM_CYC (`FTCF_DOM_NS / `FTCF_CLK_NS)
// Go-to-sleep hold time
`define FTCF_GTS_NS 50000
`define FTCF_GTS_CYC (`FTCF_GTS_NS / `FTCF_CLK_NS)

// ----------------------------------------
// Reset values and pad defaults
// ----------------------------------------
`define FTCF_PWRON_RST 1'b1
`define FTCF_INH_RST 1'b1
`define FTCF_TXD_PULL 1'b1
`define FTCF_CTRL_PULL 1'b0

`endif

// file: ftcf_pkg.sv
package ftcf_pkg;
    typedef enum logic [2:0] {
        ftcf_normal     = 3'h0,
        ftcf_pwron_stby = 3'h1,
        ftcf_goto_sleep = 3'h2,
        ftcf_standby    = 3'h3,
        ftcf_sleep      = 3'h4
    } ftcf_mode_t;
endpackage

// file: ftcf_filter.sv
`include "ftcf_consts.svh"

module ftcf_filter #(
    parameter int ENTRY_CYC = `FTCF_ENTRY_CYC,
    parameter int EXIT_CYC = `FTCF_EXIT_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic fail_in,
    output logic qual_out
);
    localparam int CW = $clog2((ENTRY_CYC > EXIT_CYC ? ENTRY_CYC : EXIT_CYC) + 1);

    generate
        if (ENTRY_CYC < 1 || EXIT_CYC < 1) begin : g_chk
            $error("ftcf_filter: delays must be at least one cycle");
        end
    endgenerate

    logic [CW-1:0] cnt_r, cnt_nxt;
    logic qual_r, qual_nxt;

    // ----------------------------------------
    // Delay filter
    // ----------------------------------------
    // Any return to the current state restarts the count, so RF bursts shorter than the delay never switch
    always_comb begin
        cnt_nxt = '0;
        qual_nxt = qual_r;
        if (fail_in != qual_r) begin
            if (!qual_r && cnt_r == CW'(ENTRY_CYC - 1)) begin
                qual_nxt = 1'b1;
            end else if (qual_r && cnt_r == CW'(EXIT_CYC - 1)) begin
                qual_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            qual_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign qual_out = qual_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    entry_hold_a: assert property (!qual_r && !fail_in |=> !qual_r)
        else $error("filter qualified without a failure");
    exit_hold_a: assert property (qual_r && fail_in |=> qual_r)
        else $error("filter released while failure present");
endmodule

// file: ftcf_top.sv
`include "ftcf_consts.svh"

module ftcf_top #(
    parameter int ENTRY_CYC = `FTCF_ENTRY_CYC,
    parameter int EXIT_CYC = `FTCF_EXIT_CYC,
    parameter int DOM_CYC = `FTCF_DOM_CYC,
    parameter int REMOTE_CYC = `FTCF_REMOTE_CYC,
    parameter int GTS_CYC = `FTCF_GTS_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic txd_in,
    input wire logic txd_drv,
    input wire logic standby_ctrl_n,
    input wire logic standby_drv,
    input wire logic mode_sel,
    input wire logic mode_drv,
    input wire logic local_wake_in,
    input wire logic diff_rx_dom,
    input wire logic canh_dom,
    input wire logic canl_dom,
    input wire logic fail_diff_only,
    input wire logic fail_canh,
    input wire logic fail_canl,
    output logic rxd_out,
    output logic fault_flag_out_n,
    output logic regulator_inhibit_out,
    output logic tx_dom_out,
    output logic canh_drv_en,
    output logic canl_drv_en,
    output logic high_wire_termination,
    output logic low_wire_termination,
    output logic single_wire_mode
);
    localparam int DW = $clog2(DOM_CYC + 1);
    localparam int RW = $clog2(REMOTE_CYC + 1);
    localparam int GW = $clog2(GTS_CYC + 1);

    generate
        if (DOM_CYC < 1 || REMOTE_CYC < 1 || GTS_CYC < 1) begin : g_chk
            $error("ftcf_top: counts must be at least one cycle");
        end
    endgenerate

    function automatic logic pad_level(input logic v, input logic drv, input logic pull);
        return drv ? v : pull;
    endfunction

    // ----------------------------------------
    // Pad defaults and mode decode
    // ----------------------------------------
    logic txd, stb_n, en;
    assign txd = pad_level(txd_in, txd_drv, `FTCF_TXD_PULL);
    assign stb_n = pad_level(standby_ctrl_n, standby_drv, `FTCF_CTRL_PULL);
    assign en = pad_level(mode_sel, mode_drv, `FTCF_CTRL_PULL);

    // ----------------------------------------
    // Failure detector
    // ----------------------------------------
    logic h_q, l_q, is_normal;
    // Filters run in every mode; only their outputs matter outside normal mode
    ftcf_filter #(.ENTRY_CYC(ENTRY_CYC), .EXIT_CYC(EXIT_CYC)) u_filt_h (
        .clock(clock),
        .resetn(resetn),
        .fail_in(fail_canh),
        .qual_out(h_q)
    );
    ftcf_filter #(.ENTRY_CYC(ENTRY_CYC), .EXIT_CYC(EXIT_CYC)) u_filt_l (
        .clock(clock),
        .resetn(resetn),
        .fail_in(fail_canl),
        .qual_out(l_q)
    );

    // Differential-only failures touch no driver, so a frame in flight survives
    assign canh_drv_en = !h_q;
    assign canl_drv_en = !l_q;
    assign high_wire_termination = !h_q;
    assign low_wire_termination = !l_q;
    assign single_wire_mode = h_q || l_q;

    // ----------------------------------------
    // Mode sequencing, wake and power-on
    // ----------------------------------------
    ftcf_pkg::ftcf_mode_t mode_r, mode_nxt;
    logic [GW-1:0] gts_r, gts_nxt;
    logic [RW-1:0] rem_r, rem_nxt;
    logic pwron_r, pwron_nxt, wake_r, wake_nxt, inh_r, inh_nxt;
    logic lw_prev_r, armed_r, wake_evt, local_evt, remote_evt, bus_dom;

    assign is_normal = (mode_r == ftcf_pkg::ftcf_normal);
    assign bus_dom = canh_dom || canl_dom;
    assign local_evt = armed_r && (local_wake_in != lw_prev_r);
    assign remote_evt = (rem_r == RW'(REMOTE_CYC - 1)) && bus_dom;
    assign wake_evt = !is_normal && (local_evt || remote_evt);

    always_comb begin
        mode_nxt = mode_r;
        gts_nxt = '0;
        rem_nxt = '0;
        pwron_nxt = pwron_r;
        wake_nxt = wake_r || wake_evt;
        inh_nxt = inh_r || wake_evt;
        if (bus_dom && !is_normal && !remote_evt) begin
            rem_nxt = rem_r + RW'(1);
        end
        unique case ({stb_n, en})
            2'b11: begin
                mode_nxt = ftcf_pkg::ftcf_normal;
                pwron_nxt = 1'b0;
                wake_nxt = 1'b0;
                inh_nxt = 1'b1;
            end
            2'b10: begin
                mode_nxt = ftcf_pkg::ftcf_pwron_stby;
                inh_nxt = 1'b1;
            end
            2'b01: begin
                if (mode_r == ftcf_pkg::ftcf_sleep) begin
                    mode_nxt = wake_evt ? ftcf_pkg::ftcf_standby : ftcf_pkg::ftcf_sleep;
                end else if (wake_evt || wake_r) begin
                    mode_nxt = ftcf_pkg::ftcf_standby;
                end else if (mode_r == ftcf_pkg::ftcf_goto_sleep && gts_r == GW'(GTS_CYC - 1)) begin
                    mode_nxt = ftcf_pkg::ftcf_sleep;
                    inh_nxt = 1'b0;
                end else begin
                    mode_nxt = ftcf_pkg::ftcf_goto_sleep;
                    gts_nxt = (mode_r == ftcf_pkg::ftcf_goto_sleep) ? gts_r + GW'(1) : '0;
                end
            end
            2'b00: begin
                mode_nxt = (inh_r || wake_evt) ? ftcf_pkg::ftcf_standby : ftcf_pkg::ftcf_sleep;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_r <= ftcf_pkg::ftcf_standby;
            gts_r <= '0;
            rem_r <= '0;
            pwron_r <= `FTCF_PWRON_RST;
            wake_r <= 1'b0;
            inh_r <= `FTCF_INH_RST;
            lw_prev_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            gts_r <= gts_nxt;
            rem_r <= rem_nxt;
            pwron_r <= pwron_nxt;
            wake_r <= wake_nxt;
            inh_r <= inh_nxt;
            // Pin level is learned one cycle after release, never as a reset value
            lw_prev_r <= local_wake_in;
            armed_r <= 1'b1;
        end
    end

    assign regulator_inhibit_out = inh_r;

    // ----------------------------------------
    // Permanent dominant guard
    // ----------------------------------------
    logic [DW-1:0] dom_r, dom_nxt;
    logic lock_r, lock_nxt;

    always_comb begin
        dom_nxt = '0;
        lock_nxt = lock_r;
        if (txd) begin
            lock_nxt = 1'b0;
        end else if (!lock_r) begin
            if (dom_r == DW'(DOM_CYC - 1)) begin
                lock_nxt = 1'b1;
            end else begin
                dom_nxt = dom_r + DW'(1);
            end
        end
    end

    // ----------------------------------------
    // Registered pin outputs
    // ----------------------------------------
    logic rxd_r, rxd_nxt, flag_r, flag_nxt, txo_r, txo_nxt;
    logic any_fail;
    assign any_fail = fail_diff_only || h_q || l_q;

    always_comb begin
        txo_nxt = is_normal && !txd && !lock_nxt;
        if (!is_normal) begin
            rxd_nxt = !wake_r;
        end else if (h_q) begin
            rxd_nxt = !canl_dom;
        end else if (l_q) begin
            rxd_nxt = !canh_dom;
        end else begin
            rxd_nxt = !diff_rx_dom;
        end
        if (is_normal) begin
            flag_nxt = !any_fail;
        end else if (mode_r == ftcf_pkg::ftcf_pwron_stby) begin
            flag_nxt = !pwron_r;
        end else begin
            flag_nxt = !wake_r;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dom_r <= '0;
            lock_r <= 1'b0;
            rxd_r <= 1'b1;
            flag_r <= 1'b1;
            txo_r <= 1'b0;
        end else begin
            dom_r <= dom_nxt;
            lock_r <= lock_nxt;
            rxd_r <= rxd_nxt;
            flag_r <= flag_nxt;
            txo_r <= txo_nxt;
        end
    end

    assign rxd_out = rxd_r;
    assign fault_flag_out_n = flag_r;
    assign tx_dom_out = txo_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    fault_flag_a: assert property (is_normal && any_fail |=> !fault_flag_out_n)
        else $error("fault flag not low on failure");
    diff_keep_a: assert property (!h_q && !l_q |-> canh_drv_en && canl_drv_en && !single_wire_mode)
        else $error("drivers off without wire failure");
    wire_off_a: assert property (h_q |-> !canh_drv_en && !high_wire_termination && canl_drv_en == !l_q)
        else $error("defective wire not switched off");
    dom_stop_a: assert property (lock_r |=> !tx_dom_out)
        else $error("dominant drive after timeout");
    // A new dominant bit right after release may already count, so look only at the release edge
    rearm_a: assert property (lock_r && txd |=> !lock_r && dom_r == '0)
        else $error("timeout not re-armed");
    pwron_clear_a: assert property (is_normal |=> !pwron_r)
        else $error("power-on flag survives normal mode");
    inh_wake_a: assert property (wake_evt |=> regulator_inhibit_out)
        else $error("inhibit not raised on wake");
    gts_cancel_a: assert property (mode_r == ftcf_pkg::ftcf_goto_sleep && wake_evt
                                   |=> mode_r != ftcf_pkg::ftcf_sleep && inh_r)
        else $error("go-to-sleep not cancelled by wake");
    // Entering normal clears the wake flag, so pins 11 are left out
    local_edge_a: assert property (!is_normal && !(stb_n && en) && local_evt |=> wake_r)
        else $error("local wake edge missed");
    remote_bus_a: assert property (!is_normal && !(stb_n && en) && bus_dom
                                   && rem_r == RW'(REMOTE_CYC - 1) |=> wake_r)
        else $error("remote wake not taken");

    single_wire_c: cover property (!single_wire_mode ##1 single_wire_mode);
    remote_wake_c: cover property (mode_r == ftcf_pkg::ftcf_sleep && remote_evt);
    timeout_c: cover property (!lock_r ##1 lock_r);
    sleep_c: cover property (mode_r == ftcf_pkg::ftcf_goto_sleep ##1 mode_r == ftcf_pkg::ftcf_sleep);
endmodule

// file: ftcf_ctrl_model.sv
module ftcf_ctrl_model (
    input wire logic clock,
    output logic txd_in,
    output logic txd_drv,
    output logic standby_ctrl_n,
    output logic standby_drv,
    output logic mode_sel,
    output logic mode_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        txd_in = 1'b1;
        txd_drv = 1'b1;
        standby_ctrl_n = 1'b0;
        standby_drv = 1'b1;
        mode_sel = 1'b0;
        mode_drv = 1'b1;
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // Released pins show the inverse of the last value, so only the pad pull gives the right reading
    task automatic set_mode(input logic stb_n, input logic en, input logic drv);
        @(posedge clock);
        standby_ctrl_n <= drv ? stb_n : ~standby_ctrl_n;
        standby_drv <= drv;
        mode_sel <= drv ? en : ~mode_sel;
        mode_drv <= drv;
    endtask

    task automatic set_txd(input logic v, input logic drv);
        @(posedge clock);
        txd_in <= drv ? v : ~txd_in;
        txd_drv <= drv;
    endtask
endmodule

// file: fault_tolerant_can_failure_control_tb_top.sv
module fault_tolerant_can_failure_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // Small counts keep the run short
    localparam int ENTRY = 4;
    localparam int EXIT = 6;
    localparam int DOM = 20;
    localparam int REMOTE = 10;
    localparam int GTS = 8;
    logic clock = 1'b0;
    logic resetn, local_wake_in, diff_rx_dom, canh_dom, canl_dom, fail_diff_only, fail_canh, fail_canl;
    logic txd_in, txd_drv, standby_ctrl_n, standby_drv, mode_sel, mode_drv;
    logic rxd_out, fault_flag_out_n, regulator_inhibit_out, tx_dom_out;
    logic canh_drv_en, canl_drv_en, high_wire_termination, low_wire_termination, single_wire_mode;
    int mismatches = 0;
    int num_checks = 0;

    ftcf_ctrl_model ftcf_ctrl_model_i (.clock(clock), .txd_in(txd_in), .txd_drv(txd_drv),
        .standby_ctrl_n(standby_ctrl_n), .standby_drv(standby_drv), .mode_sel(mode_sel), .mode_drv(mode_drv));

    ftcf_top #(.ENTRY_CYC(ENTRY), .EXIT_CYC(EXIT), .DOM_CYC(DOM), .REMOTE_CYC(REMOTE), .GTS_CYC(GTS))
    ftcf_top_i (.clock(clock), .resetn(resetn), .txd_in(txd_in), .txd_drv(txd_drv),
        .standby_ctrl_n(standby_ctrl_n), .standby_drv(standby_drv), .mode_sel(mode_sel), .mode_drv(mode_drv),
        .local_wake_in(local_wake_in), .diff_rx_dom(diff_rx_dom), .canh_dom(canh_dom), .canl_dom(canl_dom),
        .fail_diff_only(fail_diff_only), .fail_canh(fail_canh), .fail_canl(fail_canl), .rxd_out(rxd_out),
        .fault_flag_out_n(fault_flag_out_n), .regulator_inhibit_out(regulator_inhibit_out),
        .tx_dom_out(tx_dom_out), .canh_drv_en(canh_drv_en), .canl_drv_en(canl_drv_en),
        .high_wire_termination(high_wire_termination), .low_wire_termination(low_wire_termination),
        .single_wire_mode(single_wire_mode));

    initial begin
        forever #2 clock = ~clock;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic set_fail(input logic [2:0] f);
        @(posedge clock);
        {fail_diff_only, fail_canh, fail_canl} <= f;
    endtask

    task automatic set_bus(input logic [2:0] b);
        @(posedge clock);
        {diff_rx_dom, canh_dom, canl_dom} <= b;
    endtask

    task automatic chk(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Bounded wait; running out ends the run
    task automatic wait_inh(input logic v, input int bound);
        for (int i = 0; i < bound && regulator_inhibit_out !== v; i++) begin
            cyc(1);
        end
        chk("regulator_inhibit_out wait", v, regulator_inhibit_out);
        if (regulator_inhibit_out !== v) begin
            give_verdict();
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_on();
        chk("tx_dom_out", 1'b0, tx_dom_out);
        ftcf_ctrl_model_i.set_mode(1'b1, 1'b0, 1'b1);
        cyc(4);
        chk("fault_flag_out_n", 1'b0, fault_flag_out_n);
        chk("regulator_inhibit_out", 1'b1, regulator_inhibit_out);
        ftcf_ctrl_model_i.set_mode(1'b1, 1'b1, 1'b1);
        cyc(4);
        chk("fault_flag_out_n", 1'b1, fault_flag_out_n);
        ftcf_ctrl_model_i.set_mode(1'b1, 1'b0, 1'b1);
        cyc(4);
        chk("fault_flag_out_n", 1'b1, fault_flag_out_n);
        ftcf_ctrl_model_i.set_mode(1'b1, 1'b1, 1'b1);
        cyc(4);
    endtask

    task automatic t_transmit();
        ftcf_ctrl_model_i.set_txd(1'b0, 1'b1);
        cyc(DOM - 4);
        chk("tx_dom_out", 1'b1, tx_dom_out);
        cyc(8);
        chk("tx_dom_out", 1'b0, tx_dom_out);
        cyc(4);
        chk("tx_dom_out", 1'b0, tx_dom_out);
        ftcf_ctrl_model_i.set_txd(1'b1, 1'b1);
        cyc(3);
        ftcf_ctrl_model_i.set_txd(1'b0, 1'b1);
        cyc(3);
        chk("tx_dom_out", 1'b1, tx_dom_out);
        ftcf_ctrl_model_i.set_txd(1'b1, 1'b1);
        ftcf_ctrl_model_i.set_txd(1'b1, 1'b0);
        cyc(3);
        chk("tx_dom_out", 1'b0, tx_dom_out);
        ftcf_ctrl_model_i.set_txd(1'b1, 1'b1);
        cyc(2);
    endtask

    task automatic t_wire(input logic [2:0] f);
        set_fail(f);
        repeat (ENTRY - 2) @(posedge clock);
        set_fail(3'h0);
        cyc(3);
        chk("single_wire_mode", 1'b0, single_wire_mode);
        set_fail(f);
        cyc(ENTRY + 3);
        chk("single_wire_mode", 1'b1, single_wire_mode);
        chk("canh_drv_en", ~f[1], canh_drv_en);
        chk("high_wire_termination", ~f[1], high_wire_termination);
        chk("canl_drv_en", ~f[0], canl_drv_en);
        chk("low_wire_termination", ~f[0], low_wire_termination);
        chk("fault_flag_out_n", 1'b0, fault_flag_out_n);
        set_bus({1'b0, f[0], f[1]});
        cyc(2);
        chk("rxd_out", 1'b0, rxd_out);
        set_bus(3'h0);
        set_fail(3'h0);
        cyc(EXIT - 3);
        chk("single_wire_mode", 1'b1, single_wire_mode);
        cyc(6);
        chk("single_wire_mode", 1'b0, single_wire_mode);
        chk("canh_drv_en", 1'b1, canh_drv_en);
        chk("fault_flag_out_n", 1'b1, fault_flag_out_n);
    endtask

    task automatic t_diff_only();
        set_bus(3'h4);
        set_fail(3'h4);
        cyc(ENTRY + 3);
        chk("fault_flag_out_n", 1'b0, fault_flag_out_n);
        chk("single_wire_mode", 1'b0, single_wire_mode);
        chk("canh_drv_en", 1'b1, canh_drv_en);
        chk("canl_drv_en", 1'b1, canl_drv_en);
        chk("rxd_out", 1'b0, rxd_out);
        set_fail(3'h0);
        set_bus(3'h0);
        cyc(3);
        chk("fault_flag_out_n", 1'b1, fault_flag_out_n);
    endtask

    task automatic t_undriven_mode();
        ftcf_ctrl_model_i.set_mode(1'b0, 1'b0, 1'b1);
        ftcf_ctrl_model_i.set_mode(1'b0, 1'b0, 1'b0);
        ftcf_ctrl_model_i.set_txd(1'b0, 1'b1);
        cyc(4);
        chk("tx_dom_out", 1'b0, tx_dom_out);
        ftcf_ctrl_model_i.set_txd(1'b1, 1'b1);
    endtask

    task automatic t_remote();
        ftcf_ctrl_model_i.set_mode(1'b0, 1'b1, 1'b1);
        wait_inh(1'b0, GTS + 10);
        ftcf_ctrl_model_i.set_mode(1'b0, 1'b0, 1'b1);
        set_bus(3'h1);
        cyc(REMOTE - 3);
        chk("regulator_inhibit_out", 1'b0, regulator_inhibit_out);
        cyc(6);
        chk("regulator_inhibit_out", 1'b1, regulator_inhibit_out);
        cyc(2);
        chk("rxd_out", 1'b0, rxd_out);
        set_bus(3'h0);
    endtask

    task automatic t_local(input logic lvl);
        ftcf_ctrl_model_i.set_mode(1'b1, 1'b1, 1'b1);
        cyc(4);
        ftcf_ctrl_model_i.set_mode(1'b0, 1'b1, 1'b1);
        wait_inh(1'b0, GTS + 10);
        @(posedge clock);
        local_wake_in <= lvl;
        cyc(4);
        chk("regulator_inhibit_out", 1'b1, regulator_inhibit_out);
        chk("fault_flag_out_n", 1'b0, fault_flag_out_n);
    endtask

    task automatic t_gts_wake();
        ftcf_ctrl_model_i.set_mode(1'b1, 1'b1, 1'b1);
        cyc(4);
        ftcf_ctrl_model_i.set_mode(1'b0, 1'b1, 1'b1);
        cyc(3);
        @(posedge clock);
        local_wake_in <= ~local_wake_in;
        cyc(GTS + 6);
        chk("regulator_inhibit_out", 1'b1, regulator_inhibit_out);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {resetn, local_wake_in, diff_rx_dom, canh_dom, canl_dom} = 5'h00;
        {fail_diff_only, fail_canh, fail_canl} = 3'h0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        cyc(2);
        t_power_on();
        t_transmit();
        t_wire(3'h2);
        t_wire(3'h1);
        t_diff_only();
        t_undriven_mode();
        t_remote();
        t_local(1'b1);
        t_local(1'b0);
        t_gts_wake();
        give_verdict();
    end
endmodule
